//--- irq_regs.sv
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ns
module irq_regs
    import pcs_lock_pkg::*;
#(
    parameter int unsigned WIDTH = 3
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] events,
    input wire logic status_we,
    input wire logic mask_we,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] status_r,
    output logic [WIDTH-1:0] mask_r,
    output logic irq
);
    logic [WIDTH-1:0] status_nxt;
    logic [WIDTH-1:0] mask_nxt;

    // Write one clears; a new event in the same cycle keeps the bit set
    always_comb begin
        status_nxt = status_r;
        mask_nxt = mask_r;
        if (status_we) begin
            status_nxt = status_r & ~wdata;
        end
        status_nxt = status_nxt | events;
        if (mask_we) begin
            mask_nxt = wdata;
        end
    end

    // Status and mask registers, all masked off after reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            status_r <= '0;
            mask_r <= '0;
        end else begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
        end
    end

    // Level output, high while any unmasked status bit is set
    assign irq = |(status_r & mask_r);
endmodule : irq_regs

//--- link_partner.sv
// Behavioural remote partner: delivers received symbols on command
`timescale 1ns/1ns
module link_partner (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [1:0] mode,
    input wire logic gap,
    output logic rx_sym_valid,
    output logic rx_sym_idle,
    output logic rx_sym_error,
    output logic rx_in_ipg
);
    // Mode 1 idle, 2 error, 3 other data; kind lines toggle when quiet so stale values mislead
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_sym_valid <= 1'h0;
            rx_sym_idle <= 1'h0;
            rx_sym_error <= 1'h0;
            rx_in_ipg <= 1'h0;
        end else begin
            rx_sym_valid <= (mode != 2'h0);
            rx_sym_idle <= (mode == 2'h0) ? !rx_sym_idle : (mode == 2'h1);
            rx_sym_error <= (mode == 2'h0) ? !rx_sym_error : (mode == 2'h2);
            rx_in_ipg <= gap;
        end
    end
endmodule : link_partner

//--- pcs_lock_ctrl.sv
// Coding-sublayer descrambler lock control with Avalon-MM register slave
//
// Summary of operation
// R1 - Training and link-up may start only while link control is set; resets set.
// R2 - Lock-check disable bit set skips error checking during inter-packet gaps.
// R3 - Lock declared after the programmed number of idle symbols; default 120.
// R4 - Loss of lock once error symbol count reaches programmed value; default 10.
// R5 - Remote receiver status low once error count reaches its setting; default 5.
// R6 - After loss of lock, acquisition restarts with both counters cleared.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ns
module pcs_lock_ctrl
    import pcs_lock_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_sym_valid,
    input wire logic rx_sym_idle,
    input wire logic rx_sym_error,
    input wire logic rx_in_ipg,
    output logic training_enable,
    output logic link_up,
    output logic remote_rx_ok,
    output logic irq
);

    // Bus handshake state
    logic ack_r;
    logic ack_nxt;
    logic [DATA_W-1:0] readdata_r;
    logic [DATA_W-1:0] readdata_nxt;

    // Control fields
    logic link_ctrl_r;
    logic link_ctrl_nxt;
    logic ipg_dis_r;
    logic ipg_dis_nxt;
    logic [IDLE_W-1:0] idle_cfg_r;
    logic [IDLE_W-1:0] idle_cfg_nxt;
    logic [LOSS_W-1:0] loss_cfg_r;
    logic [LOSS_W-1:0] loss_cfg_nxt;
    logic [REM_W-1:0] rem_cfg_r;
    logic [REM_W-1:0] rem_cfg_nxt;

    // Lock tracking state
    lock_state_t state_r;
    lock_state_t state_nxt;
    logic link_up_r;
    logic link_up_nxt;
    logic rem_ok_r;
    logic rem_ok_nxt;

    // Decode and strobes
    logic [11:0] reg_idx;
    logic req;
    logic wr_fire;
    logic [REG_W-1:0] lane_mask;
    logic [REG_W-1:0] ctrl_one_img;
    logic [REG_W-1:0] ctrl_two_img;
    logic [REG_W-1:0] ctrl_one_new;
    logic [REG_W-1:0] ctrl_two_new;
    logic status_we;
    logic mask_we;

    // Counters and events
    logic [IDLE_W-1:0] idle_cnt;
    logic [LOSS_W-1:0] err_cnt;
    logic idle_inc;
    logic idle_clr;
    logic err_inc;
    logic err_clr;
    logic err_qual;
    logic idle_hit;
    logic loss_hit;
    logic rem_hit;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_mask;

    // Registers are word aligned, low two address bits ignored
    assign reg_idx = avs_address[ADDR_W-1:2];
    assign req = avs_read | avs_write;

    // One wait state on every access lets read data come from a flop
    assign avs_waitrequest = req & ~ack_r;
    assign wr_fire = avs_write & ack_r;
    assign avs_readdata = readdata_r;

    // Only lanes 0 and 1 carry register bits; upper lanes are ignored
    assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Current register images as software sees them
    always_comb begin
        ctrl_one_img = '0;
        ctrl_one_img[IPG_DIS_BIT] = ipg_dis_r;
        ctrl_one_img[LINK_CTRL_BIT] = link_ctrl_r;
        ctrl_one_img[IDLE_LSB +: IDLE_W] = idle_cfg_r;
        ctrl_two_img = '0;
        ctrl_two_img[LOSS_LSB +: LOSS_W] = loss_cfg_r;
        ctrl_two_img[REM_LSB +: REM_W] = rem_cfg_r;
    end

    // Byte-lane merge of write data into each image
    assign ctrl_one_new = (ctrl_one_img & ~lane_mask) | (avs_writedata[REG_W-1:0] & lane_mask);
    assign ctrl_two_new = (ctrl_two_img & ~lane_mask) | (avs_writedata[REG_W-1:0] & lane_mask);

    // Interrupt register strobes; only lane 0 holds their bits
    assign status_we = wr_fire & (reg_idx == IRQ_STATUS_IDX) & avs_byteenable[0];
    assign mask_we = wr_fire & (reg_idx == IRQ_MASK_IDX) & avs_byteenable[0];

    // Bus answer: ack one cycle after the request, read data loaded with it
    always_comb begin
        ack_nxt = req & ~ack_r;
        readdata_nxt = readdata_r;
        if (avs_read && !ack_r) begin
            readdata_nxt = '0;
            unique case (reg_idx)
                CTRL_ONE_IDX: readdata_nxt[REG_W-1:0] = ctrl_one_img;
                CTRL_TWO_IDX: readdata_nxt[REG_W-1:0] = ctrl_two_img;
                IRQ_STATUS_IDX: readdata_nxt[EV_W-1:0] = irq_status;
                IRQ_MASK_IDX: readdata_nxt[EV_W-1:0] = irq_mask;
                LINK_STATUS_IDX: begin
                    readdata_nxt[LS_LINK_UP] = link_up_r;
                    readdata_nxt[LS_REM_OK] = rem_ok_r;
                    readdata_nxt[LS_ACQUIRE] = (state_r == LK_ACQUIRE);
                    readdata_nxt[LS_ERR_LSB +: LOSS_W] = err_cnt;
                end
                default: readdata_nxt = '0;
            endcase
        end
    end

    // Bus handshake registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
            readdata_r <= '0;
        end else begin
            ack_r <= ack_nxt;
            readdata_r <= readdata_nxt;
        end
    end

    // Control field updates on the accepting edge of a write
    always_comb begin
        link_ctrl_nxt = link_ctrl_r;
        ipg_dis_nxt = ipg_dis_r;
        idle_cfg_nxt = idle_cfg_r;
        loss_cfg_nxt = loss_cfg_r;
        rem_cfg_nxt = rem_cfg_r;
        if (wr_fire && (reg_idx == CTRL_ONE_IDX)) begin
            link_ctrl_nxt = ctrl_one_new[LINK_CTRL_BIT];
            ipg_dis_nxt = ctrl_one_new[IPG_DIS_BIT];
            idle_cfg_nxt = ctrl_one_new[IDLE_LSB +: IDLE_W];
        end
        if (wr_fire && (reg_idx == CTRL_TWO_IDX)) begin
            loss_cfg_nxt = ctrl_two_new[LOSS_LSB +: LOSS_W];
            rem_cfg_nxt = ctrl_two_new[REM_LSB +: REM_W];
        end
    end

    // Control registers with their documented reset values
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link_ctrl_r <= LINK_CTRL_RST;
            ipg_dis_r <= IPG_DIS_RST;
            idle_cfg_r <= IDLE_CFG_RST;
            loss_cfg_r <= LOSS_CFG_RST;
            rem_cfg_r <= REM_CFG_RST;
        end else begin
            link_ctrl_r <= link_ctrl_nxt;
            ipg_dis_r <= ipg_dis_nxt;
            idle_cfg_r <= idle_cfg_nxt;
            loss_cfg_r <= loss_cfg_nxt;
            rem_cfg_r <= rem_cfg_nxt;
        end
    end

    // R1 training gate
    assign training_enable = link_ctrl_r;

    // R2 gap check skip
    assign err_qual = rx_sym_valid & rx_sym_error & ~(ipg_dis_r & rx_in_ipg);

    // R3 idle run count; a non-idle symbol breaks the run and starts over
    assign idle_inc = (state_r == LK_ACQUIRE) & rx_sym_valid & rx_sym_idle;
    assign idle_clr = (state_r != LK_ACQUIRE) | (rx_sym_valid & ~rx_sym_idle);
    assign idle_hit = idle_inc & (({1'b0, idle_cnt} + 10'h001) >= {1'b0, idle_cfg_r});

    // R4 error count toward loss of lock, held only while locked
    assign err_inc = (state_r == LK_LOCKED) & err_qual;
    assign loss_hit = err_inc & (({1'b0, err_cnt} + 6'h01) >= {1'b0, loss_cfg_r});

    // R5 remote receiver threshold on the same error count
    assign rem_hit = err_inc & (({1'b0, err_cnt} + 6'h01) >= {1'b0, rem_cfg_r});

    // R6 counter restart; leaving lock clears the error count for a fresh run
    assign err_clr = (state_r != LK_LOCKED);

    sym_count #(
        .WIDTH(IDLE_W)
    ) idle_counter (
        .clock(clock),
        .nrst(nrst),
        .clr(idle_clr),
        .inc(idle_inc),
        .count_r(idle_cnt)
    );

    sym_count #(
        .WIDTH(LOSS_W)
    ) err_counter (
        .clock(clock),
        .nrst(nrst),
        .clr(err_clr),
        .inc(err_inc),
        .count_r(err_cnt)
    );

    // Lock state machine; link control low forces it off from any state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            LK_OFF: begin
                // R1 start only when enabled
                if (link_ctrl_r) begin
                    state_nxt = LK_ACQUIRE;
                end
            end
            LK_ACQUIRE: begin
                // R3 lock on idle count
                if (idle_hit) begin
                    state_nxt = LK_LOCKED;
                end
            end
            LK_LOCKED: begin
                // R6 relock after loss
                if (loss_hit) begin
                    state_nxt = LK_ACQUIRE;
                end
            end
        endcase
        // R1 disable training
        if (!link_ctrl_r) begin
            state_nxt = LK_OFF;
        end
    end

    // Link and remote status follow the next state so they line up with it
    always_comb begin
        link_up_nxt = (state_nxt == LK_LOCKED);
        rem_ok_nxt = rem_ok_r;
        if (state_nxt != LK_LOCKED) begin
            rem_ok_nxt = 1'b0;
        end else if (state_r != LK_LOCKED) begin
            rem_ok_nxt = 1'b1;
        end else if (rem_hit) begin
            // R5 remote status low
            rem_ok_nxt = 1'b0;
        end
    end

    // Lock state and status registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= LK_OFF;
            link_up_r <= 1'b0;
            rem_ok_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            link_up_r <= link_up_nxt;
            rem_ok_r <= rem_ok_nxt;
        end
    end

    assign link_up = link_up_r;
    assign remote_rx_ok = rem_ok_r;

    // Events: gained lock, lost lock by errors, remote status fell while locked
    always_comb begin
        events = '0;
        events[EV_LOCK] = link_up_nxt & ~link_up_r;
        events[EV_LOSS] = (state_r == LK_LOCKED) & loss_hit;
        events[EV_REM_LOW] = rem_ok_r & rem_hit;
    end

    irq_regs #(
        .WIDTH(EV_W)
    ) irq_block (
        .clock(clock),
        .nrst(nrst),
        .events(events),
        .status_we(status_we),
        .mask_we(mask_we),
        .wdata(avs_writedata[EV_W-1:0]),
        .status_r(irq_status),
        .mask_r(irq_mask),
        .irq(irq)
    );

endmodule : pcs_lock_ctrl

//--- pcs_lock_ctrl_asserts.sv
// Port-level checks for the lock control block
`timescale 1ns/1ns
module pcs_lock_checker
    import pcs_lock_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic rx_sym_valid,
    input wire logic rx_sym_idle,
    input wire logic rx_sym_error,
    input wire logic rx_in_ipg,
    input wire logic training_enable,
    input wire logic link_up,
    input wire logic remote_rx_ok,
    input wire logic irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // Bus steps: request waiting, then the same request answered
    sequence s_req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_req_done;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence
    // Link going down
    sequence s_link_drop;
        link_up ##1 !link_up;
    endsequence

    // Every access has exactly one wait state
    a_first_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request answered without a wait state");
    a_one_wait: assert property (s_req_wait |=> s_req_done)
        else $error("request not answered after one wait state");
    // Link state follows its causes
    a_ctrl_gates_link: assert property (!training_enable |=> !link_up)
        else $error("link up while link control clear");
    a_lock_on_idle: assert property ($rose(link_up) |->
        $past(rx_sym_valid && rx_sym_idle && training_enable))
        else $error("lock without an idle symbol");
    a_lock_remote_ok: assert property ($rose(link_up) |-> remote_rx_ok)
        else $error("remote status not good at lock");
    a_remote_in_lock: assert property (remote_rx_ok |-> link_up)
        else $error("remote status good while unlocked");
    a_loss_cause: assert property (s_link_drop |->
        $past(rx_sym_valid && rx_sym_error) || !training_enable)
        else $error("link lost without an error symbol");
    a_remote_cause: assert property ($fell(remote_rx_ok) && link_up |->
        $past(rx_sym_valid && rx_sym_error))
        else $error("remote status fell without an error symbol");
endmodule : pcs_lock_checker

bind pcs_lock_ctrl pcs_lock_checker chk (.clock(clock), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_sym_valid(rx_sym_valid), .rx_sym_idle(rx_sym_idle), .rx_sym_error(rx_sym_error),
    .rx_in_ipg(rx_in_ipg), .training_enable(training_enable), .link_up(link_up),
    .remote_rx_ok(remote_rx_ok), .irq(irq));

//--- pcs_lock_pkg.sv
// Constants, register map and state type for the coding-sublayer lock control
package pcs_lock_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] CTRL_ONE_IDX = 12'h485;
    localparam logic [11:0] CTRL_TWO_IDX = 12'h486;
    localparam logic [11:0] IRQ_STATUS_IDX = 12'h4f0;
    localparam logic [11:0] IRQ_MASK_IDX = 12'h4f1;
    localparam logic [11:0] LINK_STATUS_IDX = 12'h4f2;
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 16;

    // Control register one fields
    localparam int unsigned IPG_DIS_BIT = 13;
    localparam int unsigned LINK_CTRL_BIT = 12;
    localparam int unsigned IDLE_LSB = 0;
    localparam int unsigned IDLE_W = 9;

    // Control register two fields
    localparam int unsigned LOSS_LSB = 9;
    localparam int unsigned LOSS_W = 5;
    localparam int unsigned REM_LSB = 0;
    localparam int unsigned REM_W = 5;

    // Reset values
    localparam logic LINK_CTRL_RST = 1'b1;
    localparam logic IPG_DIS_RST = 1'b0;
    localparam logic [IDLE_W-1:0] IDLE_CFG_RST = 9'h078;
    localparam logic [LOSS_W-1:0] LOSS_CFG_RST = 5'h0a;
    localparam logic [REM_W-1:0] REM_CFG_RST = 5'h05;

    // Interrupt event bits, same layout in status and mask
    localparam int unsigned EV_LOCK = 0;
    localparam int unsigned EV_LOSS = 1;
    localparam int unsigned EV_REM_LOW = 2;
    localparam int unsigned EV_W = 3;

    // Link status register fields
    localparam int unsigned LS_LINK_UP = 0;
    localparam int unsigned LS_REM_OK = 1;
    localparam int unsigned LS_ACQUIRE = 2;
    localparam int unsigned LS_ERR_LSB = 8;

    typedef enum logic [1:0] {LK_OFF, LK_ACQUIRE, LK_LOCKED} lock_state_t;

endpackage : pcs_lock_pkg

//--- sym_count.sv
// Saturating symbol counter with synchronous clear
`timescale 1ns/1ns
module sym_count
    import pcs_lock_pkg::*;
#(
    parameter int unsigned WIDTH = 9
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clr,
    input wire logic inc,
    output logic [WIDTH-1:0] count_r
);
    logic [WIDTH-1:0] count_nxt;

    // Clear wins over increment; saturate rather than wrap to zero
    always_comb begin
        count_nxt = count_r;
        if (clr) begin
            count_nxt = '0;
        end else if (inc && (count_r != {WIDTH{1'b1}})) begin
            count_nxt = count_r + 1'b1;
        end
    end

    // Count register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end
endmodule : sym_count

//--- testbench.sv
// Self-checking bench for the lock control block
`timescale 1ns/1ns
module testbench
    import pcs_lock_pkg::*;
;
    logic clock = 1'h0;
    logic nrst = 1'h0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest, rx_sym_valid, rx_sym_idle, rx_sym_error, rx_in_ipg;
    logic training_enable, link_up, remote_rx_ok, irq;
    logic [1:0] mode = 2'h0;
    logic gap = 1'h0;
    logic [31:0] seed = 32'hdab6;
    logic [31:0] rd;
    logic [15:0] w;
    int n_fail = 0;
    int checked = 0;
    int n_idle, rem_n, loss_n;

    // Clock, 20 ns period
    always #10 clock = ~clock;

    pcs_lock_ctrl dut (.clock(clock), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_sym_valid(rx_sym_valid),
        .rx_sym_idle(rx_sym_idle), .rx_sym_error(rx_sym_error), .rx_in_ipg(rx_in_ipg),
        .training_enable(training_enable), .link_up(link_up),
        .remote_rx_ok(remote_rx_ok), .irq(irq));
    link_partner peer (.clock(clock), .nrst(nrst), .mode(mode), .gap(gap),
        .rx_sym_valid(rx_sym_valid), .rx_sym_idle(rx_sym_idle),
        .rx_sym_error(rx_sym_error), .rx_in_ipg(rx_in_ipg));

    // Xorshift source; fixed start keeps runs repeatable
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Expected read-back of a control register: reserved bits are not stored
    function automatic logic [31:0] f_reg(input int i, input logic [15:0] v);
        return {16'h0, v & ((i == 0) ? 16'h31ff : 16'h3e1f)};
    endfunction : f_reg

    task automatic close_out();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask : chk_pin

    // One transfer; held until waitrequest low at an edge, upper lanes random since ignored
    task automatic bus(input logic we, input logic [11:0] idx, input logic [15:0] wd);
        int k = 0;
        @(posedge clock);
        avs_address <= {idx, 2'h0};
        avs_write <= we;
        avs_read <= !we;
        avs_writedata <= {16'(xs()), wd};
        avs_byteenable <= {2'(xs()), 2'h3};
        // Sample waitrequest and read data at the rising edge; release only after it
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'h0 && k < 50);
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(negedge clock);
        if (k >= 50) begin
            n_fail++;
            close_out();
        end
    endtask : bus

    // Partner sends n symbols of one kind; the result lands before return
    task automatic syms(input logic [1:0] kind, input int n);
        if (n > 0) begin
            @(posedge clock);
            mode <= kind;
            repeat (n) @(posedge clock);
            mode <= 2'h0;
            @(posedge clock);
            @(negedge clock);
        end
    endtask : syms

    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1'h1;
        bus(1'h0, CTRL_ONE_IDX, 16'h0);
        chk_reg(rd, 32'h1078);
        bus(1'h0, CTRL_TWO_IDX, 16'h0);
        chk_reg(rd, 32'h1405);
        bus(1'h0, 12'h4ff, 16'h0);
        chk_reg(rd, 32'h0);
        for (int i = 0; i < 2; i++) begin
            w = 16'(xs());
            bus(1'h1, CTRL_ONE_IDX + 12'(i), w);
            bus(1'h0, CTRL_ONE_IDX + 12'(i), 16'h0);
            chk_reg(rd, f_reg(i, w));
        end
        $display("regs done");
        n_idle = 2 + int'(xs() % 14);
        rem_n = 1 + int'(xs() % 6);
        loss_n = rem_n + 1 + int'(xs() % 6);
        bus(1'h1, CTRL_ONE_IDX, 16'h1000 | 16'(n_idle));
        bus(1'h1, CTRL_TWO_IDX, 16'(loss_n << 9) | 16'(rem_n));
        bus(1'h1, IRQ_MASK_IDX, 16'h7);
        bus(1'h0, IRQ_MASK_IDX, 16'h0);
        chk_reg(rd, 32'h7);
        bus(1'h1, IRQ_STATUS_IDX, 16'h7);
        syms(2'h1, n_idle - 1);
        syms(2'h3, 1);
        syms(2'h1, n_idle - 1);
        chk_pin(link_up, 1'h0);
        syms(2'h1, 1);
        chk_pin(link_up, 1'h1);
        chk_pin(irq, 1'h1);
        bus(1'h0, IRQ_STATUS_IDX, 16'h0);
        chk_reg(rd, 32'h1);
        bus(1'h1, IRQ_STATUS_IDX, 16'h1);
        chk_pin(irq, 1'h0);
        $display("lock done");
        syms(2'h2, rem_n - 1);
        chk_pin(remote_rx_ok, 1'h1);
        syms(2'h2, 1);
        chk_pin(remote_rx_ok, 1'h0);
        syms(2'h2, loss_n - rem_n - 1);
        chk_pin(link_up, 1'h1);
        syms(2'h2, 1);
        chk_pin(link_up, 1'h0);
        bus(1'h0, IRQ_STATUS_IDX, 16'h0);
        chk_reg(rd, 32'h6);
        bus(1'h1, IRQ_STATUS_IDX, 16'h6);
        syms(2'h1, n_idle - 1);
        chk_pin(link_up, 1'h0);
        syms(2'h1, 1);
        chk_pin(link_up, 1'h1);
        syms(2'h2, rem_n - 1);
        chk_pin(remote_rx_ok, 1'h1);
        bus(1'h0, LINK_STATUS_IDX, 16'h0);
        chk_reg(rd, (32'h1 << LS_LINK_UP) | (32'h1 << LS_REM_OK) | (32'(rem_n - 1) << LS_ERR_LSB));
        $display("loss done");
        bus(1'h1, CTRL_ONE_IDX, 16'h3000 | 16'(n_idle));
        @(posedge clock);
        gap <= 1'h1;
        syms(2'h2, loss_n + 2);
        chk_pin(link_up, 1'h1);
        bus(1'h1, CTRL_ONE_IDX, 16'h1000 | 16'(n_idle));
        syms(2'h2, loss_n - rem_n);
        chk_pin(link_up, 1'h1);
        syms(2'h2, 1);
        chk_pin(link_up, 1'h0);
        @(posedge clock);
        gap <= 1'h0;
        $display("gap done");
        bus(1'h1, IRQ_MASK_IDX, 16'h0);
        bus(1'h1, IRQ_STATUS_IDX, 16'h7);
        bus(1'h1, CTRL_ONE_IDX, 16'(n_idle));
        chk_pin(training_enable, 1'h0);
        syms(2'h1, n_idle);
        chk_pin(link_up, 1'h0);
        bus(1'h1, CTRL_ONE_IDX, 16'h1000 | 16'(n_idle));
        chk_pin(training_enable, 1'h1);
        syms(2'h1, n_idle);
        chk_pin(link_up, 1'h1);
        chk_pin(irq, 1'h0);
        bus(1'h0, IRQ_STATUS_IDX, 16'h0);
        chk_reg(rd, 32'h1);
        $display("control done");
        close_out();
    end
endmodule : testbench
